// ---- task_state_map.svh ----
// Offsets, field positions, reset values and codes of the task-state checker.
`ifndef TASK_STATE_MAP_SVH
`define TASK_STATE_MAP_SVH
`define IMG_BYTES       104
`define IMG_LINK_OFS    8'h00
`define IMG_PDB_OFS     8'h1c
`define IMG_IP_OFS      8'h20
`define IMG_FLAGS_OFS   8'h24
`define IMG_GPR_OFS     8'h28
`define IMG_SEG_OFS     8'h48
`define IMG_LDT_OFS     8'h60
`define IMG_IOMAP_OFS   8'h64
`define IMG_TRAP_BIT    0
`define LIVE_OFS        8'h80
`define LIVE_FLAGS_IDX  14
`define LIVE_IP_IDX     15
`define REG_DESC_LO     8'hc0
`define REG_DESC_HI     8'hc4
`define REG_DESC_EXT    8'hc8
`define REG_SEL_ARG     8'hcc
`define REG_CTRL        8'hd0
`define REG_CMD         8'hd4
`define REG_IO_PORT     8'hd8
`define REG_STATUS      8'hdc
`define REG_TR_SEL      8'he0
`define REG_TR_BASE     8'he4
`define REG_TR_LIMIT    8'he8
`define REG_TR_BASE_HI  8'hec
`define TYPE_AVAIL      4'h9
`define TYPE_BUSY       4'hb
`define MIN_LIMIT       20'h00067
`define SEL_TI_BIT      2
`define TR_SEL_RST      16'h0000
`define TR_BASE_RST     32'h00000000
`define TR_LIMIT_RST    32'h00000fff
`endif

// ---- task_state_pkg.sv ----
// Types shared by the task-state checker.
package task_state_pkg;
  typedef enum logic [2:0] {K_JMP, K_CALL, K_INT, K_IRET, K_LTR, K_SEGLOAD} kind_t;
  typedef enum logic [1:0] {OP_NONE, OP_SWITCH, OP_SAVE, OP_IOCHK} cmd_op_t;
  typedef struct packed {
    logic [25:0][31:0] image;
    logic [15:0][31:0] live;
    logic [31:0]       desc_lo;
    logic [31:0]       desc_hi;
    logic [31:0]       desc_ext;
    logic [15:0]       sel_arg;
    kind_t             kind;
    logic [1:0]        current_privilege;
    logic              mode64;
    logic [15:0]       io_port;
    logic              gp;
    logic              ts;
    logic              dbg;
    logic              done;
    logic              gp_p;
    logic              ts_p;
    logic              dbg_p;
    logic [15:0]       tr_sel;
    logic [31:0]       tr_base;
    logic [31:0]       tr_base_hi;
    logic [31:0]       tr_limit;
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic [31:0]       hrdata;
    logic              hreadyout;
  } state_t;
endpackage : task_state_pkg

// ---- task_state_checker.sv ----
// Task-state image store, descriptor checker and current-task register on AHB-Lite.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "task_state_map.svh"
module task_state_checker
  import task_state_pkg::*;
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Fault pulses.
  output logic             general_protection_fault,
  output logic             invalid_state_fault,
  output logic             debug_exception,
  // Static fields of the current image, and the current task selector.
  output logic      [15:0] local_descriptor_table,
  output logic      [31:0] page_directory_base,
  output logic      [15:0] io_map_base,
  output logic      [15:0] current_task_register
);

  state_t st;
  state_t next_st;

  logic [3:0]  d_type;
  logic [1:0]  d_dpl;
  logic        d_gran;
  logic [19:0] d_limit;
  logic [31:0] d_base;
  logic        sel_ti;
  logic        is_task_desc;
  logic        bus_req;
  logic        cmd_wr;
  cmd_op_t     cmd_op;
  logic        go_switch;
  logic        go_save;
  logic        go_io;
  logic        f_gp;
  logic        f_ts;
  logic        is_sw;
  logic [31:0] io_byte;
  logic [5:0]  rd_idx;
  logic [31:0] rd_data;

  // Descriptor fields in the usual segment-descriptor layout.
  assign d_type       = st.desc_hi[11:8];
  assign d_dpl        = st.desc_hi[14:13];
  assign d_gran       = st.desc_hi[23];
  assign d_limit      = {st.desc_hi[19:16], st.desc_lo[15:0]};
  assign d_base       = {st.desc_hi[31:24], st.desc_hi[7:0], st.desc_lo[31:16]};
  assign sel_ti       = st.sel_arg[`SEL_TI_BIT];
  assign is_task_desc = (d_type == `TYPE_AVAIL) || (d_type == `TYPE_BUSY);
  assign is_sw        = st.kind inside {K_JMP, K_CALL, K_INT, K_IRET};

  assign bus_req   = hsel && htrans[1] && hready;
  assign cmd_wr    = st.wr_pend && (st.wr_addr == `REG_CMD);
  assign cmd_op    = cmd_op_t'(hwdata[1:0]);
  assign go_switch = cmd_wr && (cmd_op == OP_SWITCH);
  assign go_save   = cmd_wr && (cmd_op == OP_SAVE);
  assign go_io     = cmd_wr && (cmd_op == OP_IOCHK);

  // The bitmap byte for a port lies at map base plus port/8 from the image start.
  assign io_byte = {16'h0000, st.image[`IMG_IOMAP_OFS >> 2][31:16]} + {19'h00000, st.io_port[15:3]};

  // Fault evaluation for a switch or load request.
  always_comb begin
    f_gp = 1'b0;
    f_ts = 1'b0;
    unique case (st.kind)
      K_SEGLOAD: begin
        f_gp = is_task_desc;
      end
      K_LTR: begin
        f_gp = sel_ti || (d_type != `TYPE_AVAIL) || (st.current_privilege != 2'h0);
      end
      K_JMP, K_CALL, K_INT, K_IRET: begin
        if (st.mode64) begin
          f_gp = 1'b1;
        end else if (sel_ti) begin
          f_gp = (st.kind != K_IRET);
          f_ts = (st.kind == K_IRET);
        end else if (st.kind == K_IRET) begin
          f_ts = (d_type != `TYPE_BUSY);
        end else if (d_type != `TYPE_AVAIL) begin
          f_gp = 1'b1;
        end else if ((st.kind != K_INT) && (st.current_privilege > d_dpl)) begin
          f_gp = 1'b1;
        end else if (!d_gran && (d_limit < `MIN_LIMIT)) begin
          f_ts = 1'b1;
        end
      end
      default: begin
        f_gp = 1'b1;
      end
    endcase
  end

  // Read mux; the image occupies the first 104 bytes contiguously.
  assign rd_idx = haddr[7:2];
  always_comb begin
    rd_data = 32'h00000000;
    if (haddr[7:0] < 8'(`IMG_BYTES)) begin
      rd_data = st.image[rd_idx];
    end else if (haddr[7:6] == 2'(`LIVE_OFS >> 6)) begin
      rd_data = st.live[rd_idx[3:0]];
    end else begin
      unique case (haddr[7:0])
        `REG_DESC_LO:    rd_data = st.desc_lo;
        `REG_DESC_HI:    rd_data = st.desc_hi;
        `REG_DESC_EXT:   rd_data = st.desc_ext;
        `REG_SEL_ARG:    rd_data = {16'h0000, st.sel_arg};
        `REG_CTRL:       rd_data = {26'h0000000, st.mode64, st.current_privilege, st.kind};
        `REG_IO_PORT:    rd_data = {16'h0000, st.io_port};
        `REG_STATUS:     rd_data = {28'h0000000, st.done, st.dbg, st.ts, st.gp};
        `REG_TR_SEL:     rd_data = {16'h0000, st.tr_sel};
        `REG_TR_BASE:    rd_data = st.tr_base;
        `REG_TR_LIMIT:   rd_data = st.tr_limit;
        `REG_TR_BASE_HI: rd_data = st.tr_base_hi;
        default:         rd_data = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    next_st           = st;
    next_st.gp_p      = 1'b0;
    next_st.ts_p      = 1'b0;
    next_st.dbg_p     = 1'b0;
    next_st.hreadyout = 1'b1;
    // Address phase: latch writes, answer reads in the following data phase.
    if (bus_req) begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = haddr[7:0];
      if (!hwrite) begin
        next_st.hrdata = rd_data;
      end
    end else begin
      next_st.wr_pend = 1'b0;
    end
    // Data phase of a write.
    if (st.wr_pend) begin
      if (st.wr_addr < 8'(`IMG_BYTES)) begin
        next_st.image[st.wr_addr[7:2]] = hwdata;
      end else if (st.wr_addr[7:6] == 2'(`LIVE_OFS >> 6)) begin
        next_st.live[st.wr_addr[5:2]] = hwdata;
      end else begin
        unique case (st.wr_addr)
          `REG_DESC_LO:  next_st.desc_lo = hwdata;
          `REG_DESC_HI:  next_st.desc_hi = hwdata;
          `REG_DESC_EXT: next_st.desc_ext = hwdata;
          `REG_SEL_ARG:  next_st.sel_arg = hwdata[15:0];
          `REG_CTRL: begin
            next_st.kind   = kind_t'(hwdata[2:0]);
            next_st.current_privilege    = hwdata[4:3];
            next_st.mode64 = hwdata[5];
          end
          `REG_IO_PORT:  next_st.io_port = hwdata[15:0];
          default: begin
          end
        endcase
      end
    end
    // A new command clears the sticky status and sets it from its own result.
    if (go_switch || go_save || go_io) begin
      next_st.gp   = 1'b0;
      next_st.ts   = 1'b0;
      next_st.dbg  = 1'b0;
      next_st.done = 1'b1;
    end
    if (go_switch) begin
      next_st.gp   = f_gp;
      next_st.ts   = f_ts;
      next_st.gp_p = f_gp;
      next_st.ts_p = f_ts;
      if (!f_gp && !f_ts && (is_sw || (st.kind == K_LTR))) begin
        next_st.tr_sel   = st.sel_arg;
        next_st.tr_base  = d_base;
        next_st.tr_limit = d_gran ? {d_limit, 12'hfff} : {12'h000, d_limit};
        // Wide descriptors carry the upper base in their third word.
        next_st.tr_base_hi = st.mode64 ? st.desc_ext : 32'h00000000;
        if (is_sw) begin
          next_st.dbg   = st.image[`IMG_IOMAP_OFS >> 2][`IMG_TRAP_BIT];
          next_st.dbg_p = st.image[`IMG_IOMAP_OFS >> 2][`IMG_TRAP_BIT];
        end
        if ((st.kind == K_CALL) || (st.kind == K_INT)) begin
          next_st.image[`IMG_LINK_OFS >> 2] = {16'h0000, st.tr_sel};
        end
      end
    end
    // Only dynamic fields are written; the static words are left alone.
    if (go_save) begin
      for (int i = 0; i < 8; i++) begin
        next_st.image[(`IMG_GPR_OFS >> 2) + i] = st.live[i];
      end
      for (int i = 0; i < 6; i++) begin
        next_st.image[(`IMG_SEG_OFS >> 2) + i] = {16'h0000, st.live[8 + i][15:0]};
      end
      next_st.image[`IMG_FLAGS_OFS >> 2] = st.live[`LIVE_FLAGS_IDX];
      next_st.image[`IMG_IP_OFS >> 2]    = st.live[`LIVE_IP_IDX];
    end
    // Only an overrun past the limit is caught here, never at switch time.
    if (go_io) begin
      next_st.gp   = (io_byte > st.tr_limit);
      next_st.gp_p = (io_byte > st.tr_limit);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st           <= '0;
      st.kind      <= K_JMP;
      st.tr_sel    <= `TR_SEL_RST;
      st.tr_base   <= `TR_BASE_RST;
      st.tr_limit  <= `TR_LIMIT_RST;
      st.hreadyout <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata                   = st.hrdata;
  assign hreadyout                = st.hreadyout;
  assign hresp                    = 1'b0 & st.hreadyout;
  assign general_protection_fault = st.gp_p;
  assign invalid_state_fault      = st.ts_p;
  assign debug_exception          = st.dbg_p;
  assign local_descriptor_table   = st.image[`IMG_LDT_OFS >> 2][15:0];
  assign page_directory_base      = st.image[`IMG_PDB_OFS >> 2];
  assign io_map_base              = st.image[`IMG_IOMAP_OFS >> 2][31:16];
  assign current_task_register    = st.tr_sel;

  // Each command check looks one cycle after the command edge, where the registered result stands.
  logic img_bus_wr;
  assign img_bus_wr = st.wr_pend && (st.wr_addr < 8'(`IMG_BYTES));

  property p_save_gpr;
    @(posedge hclk) disable iff (!hresetn)
    go_save |=> (st.image[10] == $past(st.live[0])) && (st.image[17] == $past(st.live[7]));
  endproperty
  a_save_gpr: assert property (p_save_gpr) else $error("gpr save wrong");

  property p_save_seg;
    @(posedge hclk) disable iff (!hresetn)
    go_save |=> (st.image[18] == {16'h0000, $past(st.live[8][15:0])}) && (st.image[23][31:16] == 16'h0000);
  endproperty
  a_save_seg: assert property (p_save_seg) else $error("selector save wrong");

  property p_save_flags_ip;
    @(posedge hclk) disable iff (!hresetn)
    go_save |=> (st.image[9] == $past(st.live[14])) && (st.image[8] == $past(st.live[15]));
  endproperty
  a_save_flags_ip: assert property (p_save_flags_ip) else $error("flags or ip save wrong");

  property p_link;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && !f_gp && !f_ts && ((st.kind == K_CALL) || (st.kind == K_INT)))
      |=> (st.image[0][15:0] == $past(st.tr_sel));
  endproperty
  a_link: assert property (p_link) else $error("back link not written");

  property p_static;
    @(posedge hclk) disable iff (!hresetn)
    !img_bus_wr |=> $stable(st.image[7:1]) && $stable(st.image[25:24]);
  endproperty
  a_static: assert property (p_static) else $error("static field changed");

  property p_ti_call;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && !st.mode64 && sel_ti && ((st.kind == K_CALL) || (st.kind == K_JMP)))
      |=> general_protection_fault && !invalid_state_fault;
  endproperty
  a_ti_call: assert property (p_ti_call) else $error("local selector call not faulted");

  property p_busy_call;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && !st.mode64 && !sel_ti && (st.kind == K_CALL) && (d_type == `TYPE_BUSY))
      |=> general_protection_fault ##1 !general_protection_fault;
  endproperty
  a_busy_call: assert property (p_busy_call) else $error("busy task call accepted");

  property p_limit;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && is_sw && !st.mode64 && !sel_ti && (st.kind == K_JMP) && (d_type == `TYPE_AVAIL)
      && (st.current_privilege <= d_dpl) && !d_gran && (d_limit < `MIN_LIMIT)) |=> invalid_state_fault && $stable(st.tr_sel);
  endproperty
  a_limit: assert property (p_limit) else $error("short limit accepted");

  property p_priv;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && (st.kind == K_JMP) && (st.current_privilege > d_dpl)) |=> general_protection_fault;
  endproperty
  a_priv: assert property (p_priv) else $error("privilege not checked");

  property p_seg_load;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && (st.kind == K_SEGLOAD) && is_task_desc) |=> general_protection_fault;
  endproperty
  a_seg_load: assert property (p_seg_load) else $error("segment load not faulted");

  property p_iret_ti;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && !st.mode64 && sel_ti && (st.kind == K_IRET)) |=> invalid_state_fault && !general_protection_fault;
  endproperty
  a_iret_ti: assert property (p_iret_ti) else $error("local selector return not faulted");

  property p_iret_free;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && !st.mode64 && !sel_ti && (st.kind == K_IRET) && (d_type == `TYPE_AVAIL)) |=> invalid_state_fault;
  endproperty
  a_iret_free: assert property (p_iret_free) else $error("return to idle task accepted");

  property p_upper_limit;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && (st.kind == K_JMP) && !st.mode64 && !sel_ti && (d_type == `TYPE_AVAIL) && (st.current_privilege <= d_dpl)
      && (d_limit >= `MIN_LIMIT)) |=> !invalid_state_fault && !general_protection_fault;
  endproperty
  a_upper_limit: assert property (p_upper_limit) else $error("legal limit refused at switch");

  property p_debug;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && is_sw && !f_gp && !f_ts)
      |=> (debug_exception == $past(st.image[`IMG_IOMAP_OFS >> 2][`IMG_TRAP_BIT]));
  endproperty
  a_debug: assert property (p_debug) else $error("debug trap not followed");

  property p_mode64;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && is_sw && st.mode64) |=> general_protection_fault && $stable(st.tr_sel);
  endproperty
  a_mode64: assert property (p_mode64) else $error("switch performed in 64-bit mode");

  property p_wide_ltr;
    @(posedge hclk) disable iff (!hresetn)
    (go_switch && (st.kind == K_LTR) && st.mode64 && !f_gp) |=> (st.tr_base_hi == $past(st.desc_ext));
  endproperty
  a_wide_ltr: assert property (p_wide_ltr) else $error("wide descriptor upper base lost");

  // Covers mark the main paths: a clean switch, a save, an I/O overrun, a debug trap and a wide load.
  c_switch_ok: cover property (@(posedge hclk) disable iff (!hresetn) go_switch && is_sw && !f_gp && !f_ts);
  c_save: cover property (@(posedge hclk) disable iff (!hresetn) go_save);
  c_io_fault: cover property (@(posedge hclk) disable iff (!hresetn) go_io ##1 general_protection_fault);
  c_debug: cover property (@(posedge hclk) disable iff (!hresetn) debug_exception);
  c_wide_ltr: cover property (@(posedge hclk) disable iff (!hresetn) go_switch && (st.kind == K_LTR) && st.mode64);

endmodule : task_state_checker

// ---- task_memory_model.sv ----
// System memory model holding the software-built state image and descriptor words.
`timescale 1ns/1ps
module task_memory_model;
  logic [31:0] img [26];

  // Software lays the image out as one contiguous block of 26 words before any switch.
  initial begin
    for (int i = 0; i < 26; i++) begin
      img[i] = {8'h5a, 8'(i), 8'ha5, 8'(i)};
    end
    img[0]  = 32'h00000000;
    img[25] = 32'h00680001;
  end

  function automatic logic [31:0] dlo(input logic [15:0] lim);
    return {16'h0000, lim};
  endfunction : dlo

  // Base is kept zero and present always set; only type, privilege and granularity vary.
  function automatic logic [31:0] dhi(input logic [3:0] t, input logic [1:0] descriptor_privilege, input logic g);
    return {8'h00, g, 7'h00, 1'b1, descriptor_privilege, 1'b0, t, 8'h00};
  endfunction : dhi
endmodule : task_memory_model

// ---- task_state_checker_test.sv ----
// Self-checking bench for the task-state checker over AHB-Lite.
`timescale 1ns/1ps
`include "task_state_map.svh"
module task_state_checker_test;
  import task_state_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, page_directory_base, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        general_protection_fault, invalid_state_fault, debug_exception;
  logic [15:0] local_descriptor_table, io_map_base, current_task_register;
  int          error_cnt, n_tests, dbg_cnt, gp_cnt, ts_cnt;

  task_memory_model mem_u ();
  assign hready = hreadyout;
  task_state_checker dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .general_protection_fault(general_protection_fault),
    .invalid_state_fault(invalid_state_fault), .debug_exception(debug_exception),
    .local_descriptor_table(local_descriptor_table), .page_directory_base(page_directory_base),
    .io_map_base(io_map_base), .current_task_register(current_task_register));

  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  always @(posedge hclk) begin
    if (debug_exception === 1'b1) begin
      dbg_cnt++;
    end
    if (general_protection_fault === 1'b1) begin
      gp_cnt++;
    end
    if (invalid_state_fault === 1'b1) begin
      ts_cnt++;
    end
  end

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wait_rdy;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (i == 50) begin
      error_cnt++;
      $display("MISMATCH at %0t: bus never ready", $time);
      stop_test();
    end
  endtask : wait_rdy

  // One single transfer, then an idle cycle so a read never meets the write just before it.
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
    @(posedge hclk);
  endtask : xfer

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdc

  task run(input logic [2:0] k, input logic [1:0] current_privilege, input logic m64, input logic [15:0] sel,
           input logic [31:0] hi, input logic [15:0] lim, input logic [2:0] exp);
    xfer(1'b1, `REG_DESC_LO, mem_u.dlo(lim));
    xfer(1'b1, `REG_DESC_HI, hi);
    xfer(1'b1, `REG_SEL_ARG, {16'h0000, sel});
    xfer(1'b1, `REG_CTRL, {26'h0, m64, current_privilege, k});
    xfer(1'b1, `REG_CMD, 32'h1);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk(q & 32'h7, {29'h0, exp});
  endtask : run

  task io(input logic [15:0] p, input logic [2:0] exp);
    xfer(1'b1, `REG_IO_PORT, {16'h0000, p});
    xfer(1'b1, `REG_CMD, 32'h3);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk(q & 32'h7, {29'h0, exp});
  endtask : io

  function automatic logic [31:0] live(input int i);
    return {8'hc3, 8'(i), 8'h3c, 8'(i)};
  endfunction : live

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    error_cnt = 0;
    n_tests = 0;
    dbg_cnt = 0;
    gp_cnt = 0;
    ts_cnt = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`REG_TR_SEL, 32'h0);
    rdc(`REG_TR_BASE, 32'h0);
    rdc(`REG_TR_LIMIT, 32'hfff);
    chk({16'h0, current_task_register}, 32'h0);
    run(3'h4, 2'h0, 1'b0, 16'h0008, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b0), 16'h0067, 3'b000);
    rdc(`REG_TR_SEL, 32'h8);
    for (int i = 0; i < 26; i++) begin
      xfer(1'b1, 8'(4 * i), mem_u.img[i]);
    end
    run(3'h0, 2'h0, 1'b0, 16'h0014, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b0), 16'h0067, 3'b001);
    run(3'h3, 2'h0, 1'b0, 16'h0014, mem_u.dhi(`TYPE_BUSY, 2'h0, 1'b0), 16'h0067, 3'b010);
    run(3'h5, 2'h0, 1'b0, 16'h0010, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b0), 16'h0067, 3'b001);
    run(3'h1, 2'h0, 1'b0, 16'h0010, mem_u.dhi(`TYPE_BUSY, 2'h0, 1'b0), 16'h0067, 3'b001);
    run(3'h3, 2'h0, 1'b0, 16'h0010, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b0), 16'h0067, 3'b010);
    run(3'h0, 2'h3, 1'b0, 16'h0010, mem_u.dhi(`TYPE_AVAIL, 2'h2, 1'b0), 16'h0067, 3'b001);
    run(3'h0, 2'h0, 1'b0, 16'h0010, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b0), 16'h0066, 3'b010);
    xfer(1'b1, `REG_DESC_EXT, 32'h89abcdef);
    run(3'h4, 2'h0, 1'b1, 16'h0028, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b0), 16'h0067, 3'b000);
    rdc(`REG_TR_BASE_HI, 32'h89abcdef);
    run(3'h0, 2'h0, 1'b1, 16'h0010, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b0), 16'h0067, 3'b001);
    rdc(`REG_TR_SEL, 32'h28);
    run(3'h0, 2'h2, 1'b0, 16'h0010, mem_u.dhi(`TYPE_AVAIL, 2'h2, 1'b0), 16'h0067, 3'b100);
    chk(q & 32'h8, 32'h8);
    rdc(8'h00, 32'h0);
    run(3'h1, 2'h0, 1'b0, 16'h0018, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b1), 16'h0066, 3'b100);
    rdc(`REG_TR_LIMIT, 32'h00066fff);
    rdc(8'h00, 32'h10);
    run(3'h3, 2'h0, 1'b0, 16'h0030, mem_u.dhi(`TYPE_BUSY, 2'h0, 1'b0), 16'h0067, 3'b100);
    run(3'h2, 2'h3, 1'b0, 16'h0020, mem_u.dhi(`TYPE_AVAIL, 2'h0, 1'b0), 16'h0080, 3'b100);
    rdc(8'h00, 32'h30);
    chk(32'(dbg_cnt), 32'h4);
    io(16'h00c0, 3'b000);
    io(16'h00c8, 3'b001);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, 8'(8'h80 + 4 * i), live(i));
    end
    xfer(1'b1, `REG_CMD, 32'h2);
    for (int i = 0; i < 8; i++) begin
      rdc(8'(8'h28 + 4 * i), live(i));
    end
    for (int i = 8; i < 14; i++) begin
      rdc(8'(8'h48 + 4 * (i - 8)), {16'h0, 8'h3c, 8'(i)});
    end
    rdc(8'h24, live(14));
    rdc(8'h20, live(15));
    for (int i = 1; i < 8; i++) begin
      rdc(8'(4 * i), mem_u.img[i]);
    end
    rdc(8'h60, mem_u.img[24]);
    rdc(8'h64, mem_u.img[25]);
    chk({16'h0, local_descriptor_table}, {16'h0, mem_u.img[24][15:0]});
    chk(page_directory_base, mem_u.img[7]);
    chk({16'h0, io_map_base}, 32'h68);
    chk({16'h0, current_task_register}, 32'h20);
    chk(32'(gp_cnt), 32'h6);
    chk(32'(ts_cnt), 32'h3);
    stop_test();
  end
endmodule : task_state_checker_test
